//--- verilog/module_regs_pkg.sv
// Function
// - Status bit 15 reads 1 while any generic fault is present
// - Status bit 14 reads 1 on a configuration fault
// - Status bit 13 reads 1 on a non-volatile memory fault
// - Writing 1 to status bit 12 commands a configuration save
// - Writing 1 to status bit 8 commands a whole-module reset
// - Status bits 11:9, 7:0 and error bits 15:10, 7:1 are unused
// - Error word bit 9 reads 1 on a stored-settings fault
// - Error word bit 8 reads 1 on a stored-calibration fault
// - Error word bit 0 reads 1 on a converter fault
package module_regs_pkg;
    localparam logic [15:0] ADDR_IDENTITY = 16'h9c41;
    localparam logic [15:0] ADDR_STATUS = 16'h9c42;
    localparam logic [15:0] ADDR_FW_CODE = 16'h9c7e;
    localparam logic [15:0] ADDR_FAULTS = 16'h9c7f;
    localparam int ST_GENERIC_BIT = 15;
    localparam int ST_CONFIG_BIT = 14;
    localparam int ST_NVM_BIT = 13;
    localparam int ST_SAVE_BIT = 12;
    localparam int ST_RESET_BIT = 8;
    localparam int ER_SETTING_BIT = 9;
    localparam int ER_CALIB_BIT = 8;
    localparam int ER_ADC_BIT = 0;
    localparam logic [15:0] REG_RESET_VALUE = 16'h0000;
    // Arbitrary identity values
    localparam logic [7:0] PRODUCT_CODE = 8'h5a;
    localparam logic [7:0] HW_REVISION = 8'h01;
    localparam logic [15:0] FW_CODE = 16'h0100;

    typedef struct packed {
        logic generic_fault;
        logic config_fault;
        logic nvm_fault;
        logic setting_fault;
        logic calib_fault;
        logic adc_fault;
    } fault_in_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;
endpackage : module_regs_pkg

//--- verilog/reg_read_mux.sv
`timescale 1ns/1ps
module reg_read_mux (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic rd_en_in,
    input wire logic [15:0] addr_in,
    input wire logic [15:0] status_in,
    input wire logic [15:0] faults_in,
    output logic [15:0] rdata_out,
    output logic hit_out
);
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_out <= module_regs_pkg::REG_RESET_VALUE;
            hit_out <= 1'b0;
        end else if (rd_en_in) begin
            hit_out <= 1'b1;
            case (addr_in)
                module_regs_pkg::ADDR_IDENTITY: begin
                    rdata_out <= {module_regs_pkg::PRODUCT_CODE,
                                  module_regs_pkg::HW_REVISION};
                end
                module_regs_pkg::ADDR_STATUS: begin
                    rdata_out <= status_in;
                end
                module_regs_pkg::ADDR_FW_CODE: begin
                    rdata_out <= module_regs_pkg::FW_CODE;
                end
                module_regs_pkg::ADDR_FAULTS: begin
                    rdata_out <= faults_in;
                end
                default: begin
                    rdata_out <= module_regs_pkg::REG_RESET_VALUE;
                    hit_out <= 1'b0;
                end
            endcase
        end
    end
endmodule : reg_read_mux

//--- verilog/module_status_id_registers.sv
`timescale 1ns/1ps
module module_status_id_registers (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire module_regs_pkg::reg_req_t req_in,
    input wire module_regs_pkg::fault_in_t faults_in,
    output logic [15:0] rdata_out,
    output logic rvalid_out,
    output logic rhit_out,
    output logic save_cmd_out,
    output logic module_reset_out
);
    ////////////////////////////////////////////////////////////////////////
    // Fault inputs come from other logic; two flops since their domain is open
    module_regs_pkg::fault_in_t meta_q;
    module_regs_pkg::fault_in_t sync_q;
    logic [15:0] status_word;
    logic [15:0] fault_word;
    logic rd_en;
    logic wr_status;

    function automatic logic is_status_addr(input logic [15:0] addr);
        return addr == module_regs_pkg::ADDR_STATUS;
    endfunction : is_status_addr

    function automatic logic is_mapped_addr(input logic [15:0] addr);
        return (addr == module_regs_pkg::ADDR_IDENTITY) ||
               (addr == module_regs_pkg::ADDR_STATUS) ||
               (addr == module_regs_pkg::ADDR_FW_CODE) ||
               (addr == module_regs_pkg::ADDR_FAULTS);
    endfunction : is_mapped_addr

    // Defined bits cleared, so only the spare bits remain
    function automatic logic [15:0] status_spare(input logic [15:0] word);
        logic [15:0] spare;
        spare = word;
        spare[module_regs_pkg::ST_GENERIC_BIT] = 1'b0;
        spare[module_regs_pkg::ST_CONFIG_BIT] = 1'b0;
        spare[module_regs_pkg::ST_NVM_BIT] = 1'b0;
        spare[module_regs_pkg::ST_SAVE_BIT] = 1'b0;
        spare[module_regs_pkg::ST_RESET_BIT] = 1'b0;
        return spare;
    endfunction : status_spare

    function automatic logic [15:0] fault_spare(input logic [15:0] word);
        logic [15:0] spare;
        spare = word;
        spare[module_regs_pkg::ER_SETTING_BIT] = 1'b0;
        spare[module_regs_pkg::ER_CALIB_BIT] = 1'b0;
        spare[module_regs_pkg::ER_ADC_BIT] = 1'b0;
        return spare;
    endfunction : fault_spare

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= faults_in;
            sync_q <= meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        status_word = module_regs_pkg::REG_RESET_VALUE;
        status_word[module_regs_pkg::ST_GENERIC_BIT] = sync_q.generic_fault;
        status_word[module_regs_pkg::ST_CONFIG_BIT] = sync_q.config_fault;
        status_word[module_regs_pkg::ST_NVM_BIT] = sync_q.nvm_fault;
        status_word[module_regs_pkg::ST_SAVE_BIT] = save_cmd_out;
        status_word[module_regs_pkg::ST_RESET_BIT] = module_reset_out;
        fault_word = module_regs_pkg::REG_RESET_VALUE;
        fault_word[module_regs_pkg::ER_SETTING_BIT] = sync_q.setting_fault;
        fault_word[module_regs_pkg::ER_CALIB_BIT] = sync_q.calib_fault;
        fault_word[module_regs_pkg::ER_ADC_BIT] = sync_q.adc_fault;
    end

    assign rd_en = req_in.valid && !req_in.write;
    assign wr_status = req_in.valid && req_in.write &&
                       is_status_addr(req_in.addr);

    ////////////////////////////////////////////////////////////////////////
    // Commands are one-cycle pulses; the firmware side acts on them
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            save_cmd_out <= 1'b0;
            module_reset_out <= 1'b0;
        end else begin
            save_cmd_out <= wr_status && req_in.wdata[module_regs_pkg::ST_SAVE_BIT];
            module_reset_out <= wr_status &&
                                req_in.wdata[module_regs_pkg::ST_RESET_BIT];
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rvalid_out <= 1'b0;
        end else begin
            rvalid_out <= rd_en;
        end
    end

    reg_read_mux u_mux (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .rd_en_in(rd_en),
        .addr_in(req_in.addr),
        .status_in(status_word),
        .faults_in(fault_word),
        .rdata_out(rdata_out),
        .hit_out(rhit_out)
    );

    ////////////////////////////////////////////////////////////////////////
    save_cmd_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        wr_status && req_in.wdata[module_regs_pkg::ST_SAVE_BIT]
        |=> save_cmd_out
    ) else $error("save command not issued");

    save_idle_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        save_cmd_out
        |-> $past(wr_status && req_in.wdata[module_regs_pkg::ST_SAVE_BIT])
    ) else $error("spurious save command");

    reset_cmd_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        wr_status && req_in.wdata[module_regs_pkg::ST_RESET_BIT]
        |=> module_reset_out
    ) else $error("reset command not issued");

    reset_idle_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        module_reset_out
        |-> $past(wr_status && req_in.wdata[module_regs_pkg::ST_RESET_BIT])
    ) else $error("spurious reset command");

    generic_bit_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        rd_en && is_status_addr(req_in.addr)
        |=> rdata_out[module_regs_pkg::ST_GENERIC_BIT] == $past(sync_q.generic_fault)
    ) else $error("generic fault bit wrong");

    config_bit_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        rd_en && is_status_addr(req_in.addr)
        |=> rdata_out[module_regs_pkg::ST_CONFIG_BIT] == $past(sync_q.config_fault)
    ) else $error("config fault bit wrong");

    nvm_bit_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        rd_en && is_status_addr(req_in.addr)
        |=> rdata_out[module_regs_pkg::ST_NVM_BIT] == $past(sync_q.nvm_fault)
    ) else $error("memory fault bit wrong");

    cmd_echo_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        rd_en && is_status_addr(req_in.addr)
        |=> rdata_out[module_regs_pkg::ST_SAVE_BIT] == $past(save_cmd_out) &&
            rdata_out[module_regs_pkg::ST_RESET_BIT] == $past(module_reset_out)
    ) else $error("command bits read back wrong");

    status_unused_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        rd_en && is_status_addr(req_in.addr)
        |=> status_spare(rdata_out) == 16'h0000
    ) else $error("unused status bits set");

    unused_bits_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        rd_en && req_in.addr == module_regs_pkg::ADDR_FAULTS
        |=> fault_spare(rdata_out) == 16'h0000
    ) else $error("unused error bits set");

    setting_bit_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        rd_en && req_in.addr == module_regs_pkg::ADDR_FAULTS
        |=> rdata_out[module_regs_pkg::ER_SETTING_BIT] == $past(sync_q.setting_fault)
    ) else $error("setting fault bit wrong");

    calib_bit_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        rd_en && req_in.addr == module_regs_pkg::ADDR_FAULTS
        |=> rdata_out[module_regs_pkg::ER_CALIB_BIT] == $past(sync_q.calib_fault)
    ) else $error("calibration fault bit wrong");

    adc_bit_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        rd_en && req_in.addr == module_regs_pkg::ADDR_FAULTS
        |=> rdata_out[module_regs_pkg::ER_ADC_BIT] == $past(sync_q.adc_fault)
    ) else $error("converter fault bit wrong");

    identity_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        rd_en && req_in.addr == module_regs_pkg::ADDR_IDENTITY
        |=> rdata_out == {module_regs_pkg::PRODUCT_CODE, module_regs_pkg::HW_REVISION}
    ) else $error("identity value wrong");

    read_answer_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        rd_en
        |=> rvalid_out
    ) else $error("read not answered");

    rvalid_pulse_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        rvalid_out
        |-> $past(rd_en)
    ) else $error("read valid without request");

    mapped_hit_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        rd_en && is_mapped_addr(req_in.addr)
        |=> rhit_out
    ) else $error("mapped read missed");

    unmapped_read_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        rd_en && !is_mapped_addr(req_in.addr)
        |=> !rhit_out && rdata_out == 16'h0000
    ) else $error("unmapped read answered");

    read_hold_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        !rd_en
        |=> $stable(rdata_out) && $stable(rhit_out)
    ) else $error("read result changed without read");

    sync_lag_a: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) && !$past(sys_rst_in, 2)
        |-> sync_q == $past(faults_in, 2)
    ) else $error("fault synchroniser latency wrong");

    save_seen_c: cover property (@(posedge clk_sys_in) save_cmd_out);
    reset_seen_c: cover property (@(posedge clk_sys_in) module_reset_out);
    fault_read_c: cover property (@(posedge clk_sys_in) rvalid_out && rdata_out[0]);
    unmapped_read_c: cover property (@(posedge clk_sys_in) rvalid_out && !rhit_out);
    both_cmds_c: cover property (@(posedge clk_sys_in) save_cmd_out && module_reset_out);
endmodule : module_status_id_registers

//--- test/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
    input wire logic clk_sys_in,
    output module_regs_pkg::reg_req_t req_out
);
    initial req_out = '0;
    // One-cycle strobe; address and data scrambled once released
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d);
        @(negedge clk_sys_in);
        req_out = {1'b1, wr, a, d};
        @(negedge clk_sys_in);
        req_out = {1'b0, ~wr, ~a, ~d};
    endtask : access
endmodule : bus_master_model

//--- test/module_status_id_registers_tb.sv
`timescale 1ns/1ps
module module_status_id_registers_tb;
    localparam logic [15:0] A_ID = module_regs_pkg::ADDR_IDENTITY;
    localparam logic [15:0] A_ST = module_regs_pkg::ADDR_STATUS;
    localparam logic [15:0] A_FW = module_regs_pkg::ADDR_FW_CODE;
    localparam logic [15:0] A_ER = module_regs_pkg::ADDR_FAULTS;
    localparam logic [15:0] ID_WORD = {module_regs_pkg::PRODUCT_CODE,
                                       module_regs_pkg::HW_REVISION};
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    module_regs_pkg::reg_req_t req;
    module_regs_pkg::fault_in_t flt = '0;
    logic [15:0] rdata;
    logic rvalid, rhit, save_cmd, mod_rst;
    int mismatches = 0;
    int n_tests = 0;
    initial forever #2 clk_sys_in = ~clk_sys_in;
    bus_master_model bus_master_model_inst (.clk_sys_in(clk_sys_in), .req_out(req));
    module_status_id_registers module_status_id_registers_inst (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .req_in(req), .faults_in(flt),
        .rdata_out(rdata), .rvalid_out(rvalid), .rhit_out(rhit),
        .save_cmd_out(save_cmd), .module_reset_out(mod_rst));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Outputs sampled at the falling edge inside the answer cycle
    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic hit);
        bus_master_model_inst.access(1'b0, a, 16'h0000);
        chk("rvalid", 16'h0001, {15'h0000, rvalid});
        chk("rhit", {15'h0000, hit}, {15'h0000, rhit});
        chk("rdata", exp, rdata);
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic sv, input logic rs);
        bus_master_model_inst.access(1'b1, a, d);
        chk("rvalid", 16'h0000, {15'h0000, rvalid});
        chk("save_cmd", {15'h0000, sv}, {15'h0000, save_cmd});
        chk("module_reset", {15'h0000, rs}, {15'h0000, mod_rst});
    endtask : wr
    task automatic end_of_test();
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
        rd(A_ID, ID_WORD, 1'b1);
        rd(A_FW, module_regs_pkg::FW_CODE, 1'b1);
        rd(A_ST, 16'h0000, 1'b1);
        rd(A_ER, 16'h0000, 1'b1);
        rd(16'h9c43, 16'h0000, 1'b0);
        // Each fault alone, then all together; three cycles cover the synchroniser
        for (int i = 0; i < 7; i++) begin
            @(negedge clk_sys_in);
            flt = (i == 6) ? 6'h3f : 6'h01 << i;
            repeat (3) @(negedge clk_sys_in);
            rd(A_ST, {flt[5:3], 13'h0000}, 1'b1);
            rd(A_ER, {6'h00, flt[2:1], 7'h00, flt[0]}, 1'b1);
        end
        flt = '0;
        wr(A_ST, 16'h1000, 1'b1, 1'b0);
        wr(A_ST, 16'h0100, 1'b0, 1'b1);
        wr(A_ST, 16'heeff, 1'b0, 1'b0);
        wr(A_ST, 16'h1100, 1'b1, 1'b1);
        wr(A_FW, 16'h1100, 1'b0, 1'b0);
        wr(A_ID, 16'hffff, 1'b0, 1'b0);
        rd(A_ID, ID_WORD, 1'b1);
        rd(A_FW, module_regs_pkg::FW_CODE, 1'b1);
        end_of_test();
    end
    // Whole sequence needs well under 2000 ns
    initial begin
        #20000;
        mismatches++;
        end_of_test();
    end
endmodule : module_status_id_registers_tb
